// ### logic/cep_regs.svh
// Timing and field constants for the configuration EEPROM programmer
`ifndef CEP_REGS_SVH
`define CEP_REGS_SVH
// ==========================================================
// Clock and link timing
`define CEP_CLK_NS 100
`define CEP_QTR_NS 2500
`define CEP_QTR_CYC ((`CEP_QTR_NS + `CEP_CLK_NS - 1) / `CEP_CLK_NS)
`define CEP_TWR_US 20000
`define CEP_TEC_US 25000
`define CEP_POLL_CYC ((`CEP_TEC_US * 1000) / `CEP_CLK_NS)
// ==========================================================
// Field layout
`define CEP_ADDR_BITS 17
`define CEP_ADDR_BYTES 3
`define CEP_BYTE_BITS 8
`define CEP_ACK_SLOT 4'h8
`endif

// ### logic/cep_pkg.sv
// Types for the configuration EEPROM programmer
package cep_pkg;
	typedef enum logic [2:0] {
		OP_START = 3'b000,
		OP_STOP = 3'b001,
		OP_DEV = 3'b010,
		OP_ADDR = 3'b011,
		OP_WDATA = 3'b100,
		OP_RDATA = 3'b101,
		OP_POLL = 3'b110
	} cep_op_e;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_START = 3'b001,
		S_BIT = 3'b010,
		S_STOP = 3'b011,
		S_RESP = 3'b100
	} cep_state_e;
	typedef struct packed {
		cep_op_e op;
		logic ack;
		logic raw;
		logic [23:0] arg;
	} cep_cmd_s;
	typedef struct packed {
		logic nack;
		logic refused;
		logic timeout;
		logic [7:0] data;
	} cep_rsp_s;
endpackage

// ### logic/cep_prog.sv
// Two-wire programmer for the configuration EEPROM serial port
`include "cep_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cep_prog
	import cep_pkg::*;
#(
	parameter int QTR_CYC = `CEP_QTR_CYC,
	parameter int POLL_CYC = `CEP_POLL_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// User command side
	input wire logic prog_mode_req,
	input wire logic cmd_valid,
	input wire cep_cmd_s cmd,
	output logic cmd_ready,
	output logic rsp_valid,
	output cep_rsp_s rsp,
	// Device pins
	output logic ser_en_n,
	output logic prog_serial_clock,
	input wire logic prog_serial_data_i,
	output logic prog_serial_data_o,
	output logic prog_serial_data_oe
);
	localparam int QW = $clog2(QTR_CYC + 1);
	localparam int PW = $clog2(POLL_CYC + 1);
	localparam int POLL_MAX = POLL_CYC + 64 * QTR_CYC;
	localparam logic [23:0] ADDR_MASK = 24'((1 << `CEP_ADDR_BITS) - 1);
	// One cycle per quarter would move data and clock on one edge
	if (QTR_CYC < 2 || POLL_CYC < QTR_CYC) begin : g_bad_param
		$error("cep_prog: QTR_CYC or POLL_CYC out of range");
	end

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// ==========================================================
	// Data line synchroniser
	logic sda_meta, sda_sync;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_meta <= 1'b1;
			sda_sync <= 1'b1;
		end else if (ce) begin
			sda_meta <= prog_serial_data_i;
			sda_sync <= sda_meta;
		end
	end

	// ==========================================================
	// Bit engine
	cep_state_e state, next_state;
	cep_op_e op, next_op;
	cep_rsp_s next_rsp;
	logic [QW-1:0] qcnt, next_qcnt;
	logic [PW-1:0] poll_cnt, next_poll_cnt;
	logic [1:0] ph, next_ph, bytes_left, next_bytes_left;
	logic [3:0] bit_idx, next_bit_idx;
	logic [23:0] sh, next_sh;
	logic [7:0] rx, next_rx, dev_byte, next_dev_byte;
	logic ack_flag, next_ack_flag, poll_on, next_poll_on;
	logic bus_open, next_bus_open, dirty, next_dirty;
	logic wr_pending, next_wr_pending;
	logic next_scl, next_oe, next_ser_en_n, next_cmd_ready;
	logic next_rsp_valid, tick, take, refuse, writing, done;

	assign tick = (qcnt == QW'(QTR_CYC - 1));
	assign take = cmd_valid && cmd_ready;
	assign writing = (op != OP_RDATA);

	always_comb begin
		next_state = state;
		next_op = op;
		next_rsp = rsp;
		next_qcnt = (state == S_IDLE || tick) ? '0 : qcnt + 1'b1;
		next_poll_cnt = poll_cnt;
		next_ph = ph;
		next_bytes_left = bytes_left;
		next_bit_idx = bit_idx;
		next_sh = sh;
		next_rx = rx;
		next_dev_byte = dev_byte;
		next_ack_flag = ack_flag;
		next_poll_on = poll_on;
		next_bus_open = bus_open;
		next_dirty = dirty;
		next_wr_pending = wr_pending;
		next_scl = prog_serial_clock;
		next_oe = prog_serial_data_oe;
		next_ser_en_n = ser_en_n;
		next_rsp_valid = 1'b0;
		done = 1'b0;
		// Frozen mode line keeps a pending write cycle intact
		// enable held stable
		// Not on a take: a started link must keep the enable it began with
		if (state == S_IDLE && !bus_open && !wr_pending && !take) begin
			next_ser_en_n = !prog_mode_req;
		end
		refuse = ser_en_n || (wr_pending && cmd.op != OP_POLL) ||
			(!bus_open && cmd.op != OP_START && cmd.op != OP_POLL);
		if (poll_on && poll_cnt != PW'(POLL_CYC)) begin
			next_poll_cnt = poll_cnt + 1'b1;
		end
		unique case (state)
			S_IDLE: begin
				if (take) begin
					next_op = cmd.op;
					next_ack_flag = cmd.ack;
					next_rsp = '0;
					next_ph = 2'h0;
					next_bit_idx = 4'h0;
					next_bytes_left = 2'h0;
					if (refuse) begin
						next_rsp.refused = 1'b1;
						next_state = S_RESP;
					end else begin
						unique case (cmd.op)
							OP_START: next_state = S_START;
							OP_POLL: begin
								next_state = S_START;
								next_poll_on = 1'b1;
								next_poll_cnt = '0;
								next_dev_byte = cmd.arg[7:0];
							end
							OP_STOP: next_state = S_STOP;
							OP_ADDR: begin
								next_sh = cmd.raw ? cmd.arg : (cmd.arg & ADDR_MASK);
								next_bytes_left = 2'(`CEP_ADDR_BYTES - 1);
								next_state = S_BIT;
							end
							OP_WDATA: begin
								next_sh = {rev8(cmd.arg[7:0]), 16'h0000};
								next_state = S_BIT;
							end
							default: begin
								next_sh = {cmd.arg[7:0], 16'h0000};
								next_state = S_BIT;
							end
						endcase
					end
				end
			end
			S_START: begin
				if (tick) begin
					next_ph = ph + 1'b1;
					unique case (ph)
						2'h0: next_scl = 1'b1;
						2'h1: next_oe = 1'b1;
						2'h2: next_scl = 1'b0;
						2'h3: begin
							next_bus_open = 1'b1;
							if (poll_on) begin
								next_op = OP_DEV;
								next_sh = {dev_byte, 16'h0000};
								next_bit_idx = 4'h0;
								next_bytes_left = 2'h0;
								next_state = S_BIT;
							end else begin
								next_state = S_RESP;
							end
						end
					endcase
				end else if (ph == 2'h0) begin
					next_oe = 1'b0;
				end
			end
			S_BIT: begin
				if (ph == 2'h0) begin
					next_scl = 1'b0;
					if (bit_idx != `CEP_ACK_SLOT) begin
						next_oe = writing ? !sh[23] : 1'b0;
					end else begin
						next_oe = writing ? 1'b0 : ack_flag;
					end
				end
				if (tick) begin
					next_ph = ph + 1'b1;
					unique case (ph)
						2'h0: next_scl = 1'b1;
						2'h1: begin
							if (bit_idx != `CEP_ACK_SLOT) begin
								next_rx = {rx[6:0], sda_sync};
							end else if (writing && sda_sync) begin
								next_rsp.nack = 1'b1;
							end
						end
						2'h2: next_scl = 1'b0;
						2'h3: begin
							if (bit_idx != `CEP_ACK_SLOT) begin
								next_sh = {sh[22:0], 1'b0};
								next_bit_idx = bit_idx + 1'b1;
							end else if (!writing || rsp.nack ||
								bytes_left == 2'h0) begin
								done = 1'b1;
							end else begin
								next_bytes_left = bytes_left - 1'b1;
								next_bit_idx = 4'h0;
							end
						end
					endcase
				end
				if (done) begin
					next_rsp.data = rev8(rx);
					if (op == OP_WDATA && !rsp.nack) begin
						next_dirty = 1'b1;
					end
					if (poll_on && rsp.nack) begin
						next_rsp.nack = 1'b0;
						next_state = S_STOP;
					end else begin
						if (poll_on) begin
							next_wr_pending = 1'b0;
						end
						next_poll_on = 1'b0;
						next_state = S_RESP;
					end
				end
			end
			S_STOP: begin
				if (tick) begin
					next_ph = ph + 1'b1;
					unique case (ph)
						2'h0: next_scl = 1'b1;
						2'h1: next_oe = 1'b0;
						2'h2: next_scl = 1'b1;
						2'h3: begin
							next_bus_open = 1'b0;
							next_dirty = 1'b0;
							next_wr_pending = wr_pending || dirty;
							if (!poll_on) begin
								next_state = S_RESP;
							end else if (poll_cnt == PW'(POLL_CYC)) begin
								next_poll_on = 1'b0;
								next_rsp.timeout = 1'b1;
								next_state = S_RESP;
							end else begin
								next_state = S_START;
							end
						end
					endcase
				end else if (ph == 2'h0) begin
					next_oe = 1'b1;
				end
			end
			S_RESP: begin
				next_rsp_valid = 1'b1;
				next_state = S_IDLE;
			end
			default: next_state = S_IDLE;
		endcase
		next_cmd_ready = (next_state == S_IDLE);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= S_IDLE;
			op <= OP_START;
			rsp <= '0;
			qcnt <= '0;
			poll_cnt <= '0;
			ph <= 2'h0;
			bytes_left <= 2'h0;
			bit_idx <= 4'h0;
			sh <= 24'h000000;
			rx <= 8'h00;
			dev_byte <= 8'h00;
			ack_flag <= 1'b0;
			poll_on <= 1'b0;
			bus_open <= 1'b0;
			dirty <= 1'b0;
			wr_pending <= 1'b0;
			prog_serial_clock <= 1'b1;
			prog_serial_data_oe <= 1'b0;
			prog_serial_data_o <= 1'b0;
			ser_en_n <= 1'b1;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			op <= next_op;
			rsp <= next_rsp;
			qcnt <= next_qcnt;
			poll_cnt <= next_poll_cnt;
			ph <= next_ph;
			bytes_left <= next_bytes_left;
			bit_idx <= next_bit_idx;
			sh <= next_sh;
			rx <= next_rx;
			dev_byte <= next_dev_byte;
			ack_flag <= next_ack_flag;
			poll_on <= next_poll_on;
			bus_open <= next_bus_open;
			dirty <= next_dirty;
			wr_pending <= next_wr_pending;
			prog_serial_clock <= next_scl;
			prog_serial_data_oe <= next_oe;
			prog_serial_data_o <= 1'b0;
			ser_en_n <= next_ser_en_n;
			cmd_ready <= next_cmd_ready;
			rsp_valid <= next_rsp_valid;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_data_clock_low: assert property (($changed(prog_serial_data_oe) && prog_serial_clock && $past(prog_serial_clock)) |-> $past(state) inside {S_START, S_STOP}) else $error("data moved under high clock");
	a_start_shape: assert property (($rose(prog_serial_data_oe) && prog_serial_clock && $past(prog_serial_clock)) |-> $past(state) == S_START) else $error("falling data under high clock outside start");
	a_stop_shape: assert property (($fell(prog_serial_data_oe) && prog_serial_clock && $past(prog_serial_clock)) |-> $past(state) == S_STOP) else $error("rising data under high clock outside stop");
	a_never_high: assert property (prog_serial_data_o == 1'b0) else $error("data line driven high");
	a_enable_frozen: assert property ((wr_pending || bus_open) |=> $stable(ser_en_n)) else $error("enable moved during write cycle");
	a_active_mode: assert property ((state inside {S_START, S_BIT, S_STOP}) |-> !ser_en_n) else $error("link active outside programming mode");
	a_byte_in_msg: assert property ((state == S_BIT) |-> bus_open) else $error("byte outside a message");
	a_ack_release: assert property ((state == S_BIT && writing && bit_idx == `CEP_ACK_SLOT && ph == 2'h1) |-> !prog_serial_data_oe) else $error("ack slot not released");
	a_read_ack: assert property ((state == S_BIT && !writing && bit_idx == `CEP_ACK_SLOT && ph == 2'h1) |-> prog_serial_data_oe == ack_flag) else $error("read acknowledge wrong");
	a_addr_zero: assert property ((take && !refuse && cmd.op == OP_ADDR && !cmd.raw) |=> sh[23:`CEP_ADDR_BITS] == '0) else $error("unused address bits set");
	a_data_lsb: assert property ((take && !refuse && cmd.op == OP_WDATA) |=> sh[23:16] == rev8($past(cmd.arg[7:0]))) else $error("data byte not LSB first");
	// Free count of poll length; poll_cnt itself saturates
	int poll_age;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			poll_age <= 0;
		end else if (ce) begin
			poll_age <= poll_on ? poll_age + 1 : 0;
		end
	end
	a_poll_bound: assert property (poll_on |-> poll_age <= POLL_MAX) else $error("poll ran past its bound");
	c_poll_ok: cover property (poll_on ##1 (!poll_on && !rsp.timeout));
	c_read_ack: cover property (state == S_BIT && !writing && ack_flag && bit_idx == `CEP_ACK_SLOT);
	c_timeout: cover property (rsp_valid && rsp.timeout);
	c_refused: cover property (rsp_valid && rsp.refused);
endmodule // cep_prog
`default_nettype wire

// ### sim/cep_dev_model.sv
// Behavioural model of the configuration EEPROM serial port
`timescale 1ns/1ps
`default_nettype none
module cep_dev_model #(
	parameter int BUSY_NS = 30000,
	// Arbitrary device address value
	parameter logic [6:0] DEV_ID = 7'h50,
	parameter logic [23:0] ERASE_ADDR = 24'h800000
) (
	// Pins
	input wire logic scl,
	input wire logic sda,
	input wire logic en_n,
	input wire logic lock,
	output logic sda_oe
);
	logic [7:0] mem [0:131071];
	logic [7:0] sh, tx;
	logic [23:0] ab;
	logic [16:0] addr;
	logic act, rd, snd, ackn, busy, sec, wrote;
	int bitn, idx;
	// ====================
	// Array and lock
	// blank array clears lock
	task automatic blank();
		foreach (mem[i]) mem[i] = 8'h00;
		sec = 1'b0;
	endtask
	initial begin
		blank();
		{sda_oe, act, snd, busy, wrote} = '0;
		addr = '0;
		ab = '0;
	end
	always @(posedge lock) sec = 1'b1;
	task automatic take();
		ackn = 1'b1;
		if (idx == 0) begin
			rd = sh[0];
			ackn = (sh[7:1] == DEV_ID) && !(rd && sec);
		end else if (idx < 4) begin
			ab = {ab[15:0], sh};
			addr = ab[16:0];
			ackn = idx < 3 || ab[23:17] == 7'h00 || ab == ERASE_ADDR;
		end else if (ab == ERASE_ADDR) begin
			blank();
			wrote = 1'b1;
		end else if (sec) begin
			ackn = 1'b0;
		end else begin
			mem[addr] = sh;
			addr++;
			wrote = 1'b1;
		end
		idx++;
	endtask
	// ====================
	// Line handling
	// start restarts unless busy
	always @(negedge sda) if (scl && !en_n && !busy) begin
		act = 1'b1;
		snd = 1'b0;
		idx = 0;
		bitn = 0;
	end
	// stop after a write starts the busy time
	always @(posedge sda) if (scl && !en_n && !busy) begin
		act = 1'b0;
		if (wrote) begin
			busy = 1'b1;
			wrote = 1'b0;
			busy <= #(BUSY_NS) 1'b0;
		end
	end
	// address bytes MSB first, data LSB first
	always @(posedge scl) if (act) begin
		if (bitn < 8) begin
			sh = (idx >= 4 && !rd) ? {sda, sh[7:1]} : {sh[6:0], sda};
			if (bitn == 7 && !snd) take();
			bitn++;
		end else begin
			bitn = 0;
			if (snd) begin
				addr++;
				tx = mem[addr];
				act = !sda;
			end else if (!ackn) begin
				act = 1'b0;
			end else if (rd) begin
				snd = 1'b1;
				tx = mem[addr];
			end
		end
	end
	// only pulls low, moves with clock low
	always @(negedge scl) if (act) begin
		if (bitn == 8) sda_oe = ackn && !snd;
		else sda_oe = snd && !tx[bitn];
	end
endmodule // cep_dev_model
`default_nettype wire

// ### sim/config_eeprom_serial_prog_port_tb_top.sv
// Self-checking bench for the configuration EEPROM programmer
`timescale 1ns/1ps
`default_nettype none
module config_eeprom_serial_prog_port_tb_top
	import cep_pkg::*;
;
	localparam logic [10:0] OK = 11'h000;
	localparam logic [10:0] REF = 11'h200;
	localparam logic [10:0] TMO = 11'h100;
	localparam logic [10:0] NAK = 11'h400;
	logic clk, arst_n, prog_mode_req, cmd_valid, cmd_ready, rsp_valid;
	logic ser_en_n, scl, sda_i, sda_o, sda_oe, dev_oe, lock;
	cep_cmd_s cmd;
	cep_rsp_s rsp;
	int err_total, n_compared;
	// Pull-up: line high unless someone pulls
	assign sda_i = !(sda_oe || dev_oe);
	cep_prog #(.QTR_CYC(2), .POLL_CYC(500)) cep_prog_inst (
		.clk(clk), .arst_n(arst_n), .ce(1'b1),
		.prog_mode_req(prog_mode_req), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
		.ser_en_n(ser_en_n), .prog_serial_clock(scl),
		.prog_serial_data_i(sda_i), .prog_serial_data_o(sda_o),
		.prog_serial_data_oe(sda_oe));
	cep_dev_model cep_dev_model_inst (.scl(scl), .sda(sda_i),
		.en_n(ser_en_n), .lock(lock), .sda_oe(dev_oe));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ====================
	// Tasks
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [10:0] got, exp, input string m);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Data field only meaningful after a read
	task automatic run(input cep_op_e op, input logic [23:0] arg,
		input logic [10:0] exp, input logic ack = 1'b0,
		input logic raw = 1'b0);
		int n;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op, ack, raw, arg};
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 9000);
		@(posedge clk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 9000);
		if (n >= 9000) begin
			err_total++;
			$display("[FAIL] %0t wait timed out", $time);
			stop_test();
		end
		chk(op == OP_RDATA ? rsp : {rsp[10:8], 8'h00}, exp, "response");
	endtask
	task automatic rd2(input logic [23:0] a, input logic [7:0] d0, d1);
		run(OP_ADDR, a, OK);
		run(OP_START, '0, OK);
		run(OP_DEV, 24'hA1, OK);
		run(OP_RDATA, '0, {3'b000, d0}, 1'b1);
		run(OP_RDATA, '0, {3'b000, d1});
		run(OP_STOP, '0, OK);
	endtask
	always @(negedge clk) chk({10'h000, sda_o}, OK, "drive high");
	// ====================
	// Sequence
	initial begin
		arst_n = 1'b0;
		prog_mode_req = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		lock = 1'b0;
		err_total = 0;
		n_compared = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		run(OP_START, '0, REF);
		@(posedge clk) prog_mode_req <= 1'b1;
		repeat (3) @(posedge clk);
		run(OP_DEV, 24'hA0, REF);
		run(OP_START, '0, OK);
		run(OP_DEV, 24'hA2, NAK);
		run(OP_START, '0, OK);
		run(OP_DEV, 24'hA0, OK);
		run(OP_ADDR, 24'hFFFFFF, OK);
		run(OP_WDATA, 24'h11, OK);
		run(OP_WDATA, 24'h22, OK);
		run(OP_STOP, '0, OK);
		@(posedge clk) prog_mode_req <= 1'b0;
		run(OP_START, '0, REF);
		chk({10'h000, ser_en_n}, OK, "enable moved");
		@(posedge clk) prog_mode_req <= 1'b1;
		run(OP_POLL, 24'hA0, OK);
		rd2(24'h01FFFF, 8'h11, 8'h22);
		run(OP_START, '0, OK);
		run(OP_DEV, 24'hA1, OK);
		run(OP_RDATA, '0, OK);
		run(OP_STOP, '0, OK);
		lock <= 1'b1;
		run(OP_START, '0, OK);
		run(OP_DEV, 24'hA1, NAK);
		run(OP_START, '0, OK);
		run(OP_DEV, 24'hA0, OK);
		run(OP_ADDR, 24'h800000, OK, 1'b0, 1'b1);
		run(OP_WDATA, '0, OK);
		run(OP_STOP, '0, OK);
		run(OP_POLL, 24'hA0, OK);
		rd2(24'h01FFFF, 8'h00, 8'h00);
		run(OP_POLL, 24'hA2, TMO);
		stop_test();
	end
endmodule // config_eeprom_serial_prog_port_tb_top
`default_nettype wire
